//--- rtl/uecs_top.sv
// USB function control/status registers with APB access and engine hooks.
// Assumes an APB master on pclk and a protocol engine on the same clock.
`timescale 1ns/10ps
module uecs_top #(
  parameter int SOF_CYCLES = uecs_pkg::SOF_PERIOD_CYCLES,
  parameter logic [uecs_pkg::MT_ENTRIES*uecs_pkg::MT_ENTRY_W-1:0] MODE_TABLE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uecs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_dplus,
  input wire logic sof_pulse,
  input wire logic tok_valid,
  input wire logic [1:0] tok_ep,
  input wire logic tok_is_in,
  output logic resp_valid,
  output logic [1:0] resp_code,
  input wire logic xfer_done,
  input wire logic [1:0] xfer_ep,
  input wire logic xfer_acked,
  input wire logic xfer_naked,
  output logic osc_autotune_on,
  output logic osc_trim_up,
  output logic osc_trim_down,
  output logic supply_regulator_select,
  output logic irq
);
  import uecs_pkg::*;

  // Bus decode
  logic setup_phase, access_wr, lane0;
  logic [7:0] word_idx;
  logic addr_ok;
  logic sel_misc, sel_stat, sel_mask;
  logic [NUM_EP-1:0] sel_ep;
  logic [31:0] rd_mux;

  // Register state
  logic [7:0] misc_ff, nxt_misc;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] ep_ctl [NUM_EP];
  logic [31:0] prdata_ff, nxt_prdata;
  logic slverr_ff, nxt_slverr;
  logic resp_valid_ff, nxt_resp_valid;
  logic [1:0] resp_code_ff, nxt_resp_code;

  // Engine side helpers
  logic traffic_seen;
  logic [NUM_EP-1:0] ack_evt, nak_evt;
  logic [EP_MODE_W-1:0] tok_mode, xfer_mode, next_mode;
  logic tok_stall;
  logic [1:0] tbl_in, tbl_out;
  logic tbl_ack_in, tbl_ack_out;

  assign setup_phase = psel && !penable;
  // A transfer flagged in its setup cycle never writes
  assign access_wr = psel && penable && pwrite && !slverr_ff;
  assign lane0 = pstrb[0];
  assign word_idx = paddr[9:2];

  always_comb begin
    sel_misc = 1'b0;
    sel_stat = 1'b0;
    sel_mask = 1'b0;
    sel_ep = '0;
    addr_ok = 1'b1;
    if (paddr[ADDR_W-1:10] != '0 || paddr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end else if (word_idx == IDX_MISC) begin
      sel_misc = 1'b1;
    end else if (word_idx == IDX_EP1) begin
      sel_ep[0] = 1'b1;
    end else if (word_idx == IDX_EP2) begin
      sel_ep[1] = 1'b1;
    end else if (word_idx == IDX_EP3) begin
      sel_ep[2] = 1'b1;
    end else if (word_idx == IDX_EP4) begin
      sel_ep[3] = 1'b1;
    end else if (word_idx == IDX_IRQ_STATUS) begin
      sel_stat = 1'b1;
    end else if (word_idx == IDX_IRQ_MASK) begin
      sel_mask = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (sel_misc) begin
      rd_mux = {24'h000000, misc_ff};
    end else if (sel_ep[0]) begin
      rd_mux = {24'h000000, ep_ctl[0]};
    end else if (sel_ep[1]) begin
      rd_mux = {24'h000000, ep_ctl[1]};
    end else if (sel_ep[2]) begin
      rd_mux = {24'h000000, ep_ctl[2]};
    end else if (sel_ep[3]) begin
      rd_mux = {24'h000000, ep_ctl[3]};
    end else if (sel_stat) begin
      rd_mux = {24'h000000, stat_ff};
    end else if (sel_mask) begin
      rd_mux = {24'h000000, mask_ff};
    end
  end

  // Read data and error are captured in the setup cycle, so no wait states
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_slverr = slverr_ff;
    if (setup_phase) begin
      nxt_prdata = pwrite ? 32'h00000000 : rd_mux;
      nxt_slverr = !addr_ok;
    end
  end

  // Misc control: traffic flag cannot be set by software
  always_comb begin
    nxt_misc = misc_ff;
    if (access_wr && sel_misc && lane0) begin
      nxt_misc = (misc_ff & ~MISC_RW_MASK) | (pwdata[7:0] & MISC_RW_MASK);
      if (!pwdata[MISC_TRAFFIC_BIT]) begin
        nxt_misc[MISC_TRAFFIC_BIT] = 1'b0;
      end
    end
    // Hardware set comes last so it beats a clearing write
    if (traffic_seen) begin
      nxt_misc[MISC_TRAFFIC_BIT] = 1'b1;
    end
    nxt_misc[7:3] = 5'h00;
  end

  // Endpoint event decode
  always_comb begin
    ack_evt = '0;
    nak_evt = '0;
    for (int i = 0; i < NUM_EP; i++) begin
      if (xfer_done && xfer_ep == 2'(i)) begin
        ack_evt[i] = xfer_acked;
        nak_evt[i] = xfer_naked && ep_ctl[i][EP_NAKIE_BIT];
      end
    end
  end

  // Interrupt status (write one to clear, set wins) and mask
  always_comb begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    if (access_wr && sel_stat && lane0) begin
      nxt_stat = stat_ff & ~pwdata[7:0];
    end
    if (access_wr && sel_mask && lane0) begin
      nxt_mask = pwdata[7:0];
    end
    nxt_stat = nxt_stat | {nak_evt, ack_evt};
  end

  // Mode lookups for the token and for the transfer outcome
  assign tok_mode = ep_ctl[tok_ep][EP_MODE_LSB +: EP_MODE_W];
  assign tok_stall = ep_ctl[tok_ep][EP_STALL_BIT];
  assign xfer_mode = ep_ctl[xfer_ep][EP_MODE_LSB +: EP_MODE_W];

  uecs_mode_table #(
    .MODE_TABLE(MODE_TABLE)
  ) u_tok_table (
    .mode(tok_mode),
    .in_resp(tbl_in),
    .out_resp(tbl_out),
    .is_ack_in(tbl_ack_in),
    .is_ack_out(tbl_ack_out),
    .next_mode()
  );

  uecs_mode_table #(
    .MODE_TABLE(MODE_TABLE)
  ) u_xfer_table (
    .mode(xfer_mode),
    .in_resp(),
    .out_resp(),
    .is_ack_in(),
    .is_ack_out(),
    .next_mode(next_mode)
  );

  // Token answer, one cycle after the token
  // Stall only overrides in the direction that the mode acknowledges
  always_comb begin
    nxt_resp_valid = tok_valid;
    nxt_resp_code = RESP_NONE;
    if (tok_valid) begin
      if (tok_stall && tok_is_in && tbl_ack_in) begin
        nxt_resp_code = RESP_STALL;
      end else if (tok_stall && !tok_is_in && tbl_ack_out) begin
        nxt_resp_code = RESP_STALL;
      end else begin
        nxt_resp_code = tok_is_in ? tbl_in : tbl_out;
      end
    end
  end

  // Per-endpoint control registers
  for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
    logic [7:0] ctl_ff, nxt_ctl;
    logic wr_hit;
    assign wr_hit = access_wr && sel_ep[g] && lane0;

    always_comb begin
      nxt_ctl = ctl_ff;
      if (wr_hit) begin
        nxt_ctl[EP_STALL_BIT] = pwdata[EP_STALL_BIT];
        nxt_ctl[EP_NAKIE_BIT] = pwdata[EP_NAKIE_BIT];
        nxt_ctl[EP_MODE_LSB +: EP_MODE_W] = pwdata[EP_MODE_LSB +: EP_MODE_W];
        nxt_ctl[EP_ACKED_BIT] = 1'b0;
      end else if (ack_evt[g]) begin
        nxt_ctl[EP_MODE_LSB +: EP_MODE_W] = next_mode;
      end
      // An ACK in the cycle of a write still sets the flag
      if (ack_evt[g]) begin
        nxt_ctl[EP_ACKED_BIT] = 1'b1;
      end
      // Reserved bit always reads zero
      nxt_ctl[6] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_ff <= EP_RESET;
      end else begin
        ctl_ff <= nxt_ctl;
      end
    end

    assign ep_ctl[g] = ctl_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_ff <= MISC_RESET;
      stat_ff <= IRQ_RESET;
      mask_ff <= IRQ_RESET;
      prdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_code_ff <= RESP_NONE;
    end else begin
      misc_ff <= nxt_misc;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
      resp_valid_ff <= nxt_resp_valid;
      resp_code_ff <= nxt_resp_code;
    end
  end

  // D+ passes two flops in here before any logic reads it
  uecs_line_monitor #(
    .SOF_CYCLES(SOF_CYCLES),
    .TOL_CYCLES(TRIM_TOL_CYCLES)
  ) u_line (
    .pclk(pclk),
    .presetn(presetn),
    .usb_dplus(usb_dplus),
    .sof_pulse(sof_pulse),
    .autotune_on(misc_ff[MISC_AUTOTUNE_BIT]),
    .traffic_seen(traffic_seen),
    .trim_up(osc_trim_up),
    .trim_down(osc_trim_down)
  );

  assign prdata = prdata_ff;
  // Zero wait states: every access ends at its first access edge
  assign pready = 1'b1;
  assign pslverr = slverr_ff;
  assign resp_valid = resp_valid_ff;
  assign resp_code = resp_code_ff;
  assign osc_autotune_on = misc_ff[MISC_AUTOTUNE_BIT];
  assign supply_regulator_select = misc_ff[MISC_REGSEL_BIT];
  assign irq = |(stat_ff & mask_ff);
endmodule // uecs_top

//--- common/uecs_pkg.sv
// Shared constants for the USB endpoint control and status block.
// Assumes a 20 MHz pclk and an APB slave with 32-bit data.
package uecs_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_MISC = 8'hc1;
  localparam logic [7:0] IDX_EP1 = 8'hc4;
  localparam logic [7:0] IDX_EP2 = 8'hc5;
  localparam logic [7:0] IDX_EP3 = 8'hc6;
  localparam logic [7:0] IDX_EP4 = 8'hc7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'he1;
  localparam int ADDR_W = 12;
  localparam int NUM_EP = 4;
  // Misc control fields
  localparam int MISC_TRAFFIC_BIT = 2;
  localparam int MISC_AUTOTUNE_BIT = 1;
  localparam int MISC_REGSEL_BIT = 0;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] MISC_RW_MASK = 8'h03;
  // Endpoint control fields
  localparam int EP_STALL_BIT = 7;
  localparam int EP_NAKIE_BIT = 5;
  localparam int EP_ACKED_BIT = 4;
  localparam int EP_MODE_LSB = 0;
  localparam int EP_MODE_W = 4;
  localparam logic [7:0] EP_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  // Handshake answer codes towards the protocol engine
  localparam logic [1:0] RESP_NONE = 2'h0;
  localparam logic [1:0] RESP_ACK = 2'h1;
  localparam logic [1:0] RESP_NAK = 2'h2;
  localparam logic [1:0] RESP_STALL = 2'h3;
  // Mode table entry layout, one 16-bit word per mode
  localparam int MT_IN_LSB = 0;
  localparam int MT_OUT_LSB = 2;
  localparam int MT_ACKIN_BIT = 10;
  localparam int MT_ACKOUT_BIT = 11;
  localparam int MT_NEXT_LSB = 12;
  localparam int MT_ENTRY_W = 16;
  localparam int MT_ENTRIES = 16;
  // Frame start spacing and oscillator trim window
  localparam int CLK_PERIOD_NS = 50;
  localparam int SOF_PERIOD_NS = 1000000;
  localparam int SOF_PERIOD_CYCLES = SOF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TRIM_TOL_NS = 500;
  localparam int TRIM_TOL_CYCLES = (TRIM_TOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOF_CNT_W = 16;
endpackage

//--- rtl/uecs_mode_table.sv
// Endpoint mode lookup: answer class and follow-on mode for one mode code.
// Assumes the table contents are supplied by whoever knows the mode encoding.
`timescale 1ns/10ps
module uecs_mode_table #(
  parameter logic [uecs_pkg::MT_ENTRIES*uecs_pkg::MT_ENTRY_W-1:0] MODE_TABLE = '0
) (
  input wire logic [uecs_pkg::EP_MODE_W-1:0] mode,
  output logic [1:0] in_resp,
  output logic [1:0] out_resp,
  output logic is_ack_in,
  output logic is_ack_out,
  output logic [uecs_pkg::EP_MODE_W-1:0] next_mode
);
  import uecs_pkg::*;
  logic [MT_ENTRY_W-1:0] entry;

  always_comb begin
    entry = MODE_TABLE[mode*MT_ENTRY_W +: MT_ENTRY_W];
    in_resp = entry[MT_IN_LSB +: 2];
    out_resp = entry[MT_OUT_LSB +: 2];
    is_ack_in = entry[MT_ACKIN_BIT];
    is_ack_out = entry[MT_ACKOUT_BIT];
    next_mode = entry[MT_NEXT_LSB +: EP_MODE_W];
  end
endmodule // uecs_mode_table

//--- rtl/uecs_line_monitor.sv
// D+ line synchroniser, idle detection and frame-based oscillator trim.
// Assumes the D+ pin is asynchronous and sof_pulse comes from pclk logic.
`timescale 1ns/10ps
module uecs_line_monitor #(
  parameter int SOF_CYCLES = uecs_pkg::SOF_PERIOD_CYCLES,
  parameter int TOL_CYCLES = uecs_pkg::TRIM_TOL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic usb_dplus,
  input wire logic sof_pulse,
  input wire logic autotune_on,
  output logic traffic_seen,
  output logic trim_up,
  output logic trim_down
);
  import uecs_pkg::*;
  typedef enum logic [1:0] {
    ST_WAIT_FIRST = 2'b01,
    ST_MEASURE = 2'b10
  } uecs_tune_state_t;
  localparam logic [SOF_CNT_W-1:0] CNT_LO = SOF_CNT_W'(SOF_CYCLES - TOL_CYCLES);
  localparam logic [SOF_CNT_W-1:0] CNT_HI = SOF_CNT_W'(SOF_CYCLES + TOL_CYCLES);
  localparam logic [SOF_CNT_W-1:0] CNT_MAX = '1;

  logic sync1_ff, sync2_ff;
  uecs_tune_state_t state_ff, nxt_state;
  logic [SOF_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic up_ff, nxt_up, down_ff, nxt_down;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 1'b1;
    nxt_up = 1'b0;
    nxt_down = 1'b0;
    case (state_ff)
      ST_WAIT_FIRST: begin
        nxt_cnt = '0;
        if (autotune_on && sof_pulse) begin
          nxt_state = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (!autotune_on) begin
          nxt_state = ST_WAIT_FIRST;
        end else if (sof_pulse) begin
          nxt_cnt = '0;
          // Too few cycles per frame means the oscillator runs slow
          nxt_up = (cnt_ff < CNT_LO);
          nxt_down = (cnt_ff > CNT_HI);
        end
      end
      default: nxt_state = ST_WAIT_FIRST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      state_ff <= ST_WAIT_FIRST;
      cnt_ff <= '0;
      up_ff <= 1'b0;
      down_ff <= 1'b0;
    end else begin
      sync1_ff <= usb_dplus;
      sync2_ff <= sync1_ff;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
      down_ff <= nxt_down;
    end
  end

  assign traffic_seen = ~sync2_ff;
  assign trim_up = up_ff;
  assign trim_down = down_ff;
endmodule // uecs_line_monitor

//--- bench/uecs_props.sv
// Port-level checks for the USB endpoint control block.
// Assumes one pclk domain and the zero-wait APB slave of the block.
`timescale 1ns/10ps
module uecs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uecs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sof_pulse,
  input wire logic tok_valid,
  input wire logic resp_valid,
  input wire logic xfer_done,
  input wire logic osc_autotune_on,
  input wire logic osc_trim_up,
  input wire logic osc_trim_down,
  input wire logic supply_regulator_select,
  input wire logic irq
);
  import uecs_pkg::*;
  logic [7:0] idx;
  logic map_ok;
  assign idx = paddr[9:2];
  assign map_ok = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && idx inside {IDX_MISC,
    IDX_EP1, IDX_EP2, IDX_EP3, IDX_EP4, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_misc;
    s_acc ##0 paddr == {2'h0, IDX_MISC, 2'h0};
  endsequence
  a_resp_latency: assert property (tok_valid |=> resp_valid)
    else $error("no answer after token");
  a_resp_spurious: assert property (!tok_valid |=> !resp_valid)
    else $error("answer without token");
  a_map_error: assert property (s_acc |-> pslverr == !map_ok)
    else $error("wrong error flag");
  a_misc_write: assert property (s_misc ##0 pwrite && pstrb[0] |=>
    osc_autotune_on == $past(pwdata[1]) && supply_regulator_select == $past(pwdata[0]))
    else $error("misc write not applied");
  a_misc_read: assert property (s_misc ##0 !pwrite |-> prdata[31:3] == 29'h0 &&
    prdata[1:0] == {osc_autotune_on, supply_regulator_select})
    else $error("misc read mismatch");
  a_trim_cause: assert property (osc_trim_up || osc_trim_down |->
    $past(sof_pulse) || $past(sof_pulse, 2))
    else $error("trim without frame");
  a_trim_off: assert property (!osc_autotune_on [*3] |-> !osc_trim_up && !osc_trim_down)
    else $error("trim while disabled");
  a_trim_excl: assert property (!(osc_trim_up && osc_trim_down))
    else $error("trim both ways");
  a_irq_rise: assert property ($rose(irq) |-> $past(xfer_done) ||
    $past(psel && penable && pwrite))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
endmodule // uecs_props
bind uecs_top uecs_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .sof_pulse(sof_pulse), .tok_valid(tok_valid),
  .resp_valid(resp_valid), .xfer_done(xfer_done), .osc_autotune_on(osc_autotune_on),
  .osc_trim_up(osc_trim_up), .osc_trim_down(osc_trim_down),
  .supply_regulator_select(supply_regulator_select), .irq(irq));

//--- bench/uecs_host_model.sv
// Bus-side stand-in: D+ line level and start-of-frame timing.
// Assumes the block samples both on the rising edge of pclk.
`timescale 1ns/10ps
module uecs_host_model (
  input wire logic pclk,
  output logic usb_dplus,
  output logic sof_pulse
);
  // D+ rests high between packets
  initial begin
    usb_dplus = 1'b1;
    sof_pulse = 1'b0;
  end
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      usb_dplus <= i[0];
    end
    @(posedge pclk);
    usb_dplus <= 1'b1;
  endtask
  task automatic frame(input int gap);
    repeat (gap - 1) @(posedge pclk);
    sof_pulse <= 1'b1;
    @(posedge pclk);
    sof_pulse <= 1'b0;
  endtask
endmodule // uecs_host_model

//--- bench/tb_top.sv
// Self-checking bench for the USB endpoint control block.
// Assumes the host model drives D+ and frame starts; the bench is APB master and engine.
`timescale 1ns/10ps
module tb_top;
  import uecs_pkg::*;
  localparam int SOFC = 200;
  logic pclk, presetn, psel, penable, pwrite, tok_valid, tok_is_in, xfer_done, xfer_acked;
  logic xfer_naked, pready, pslverr, usb_dplus, sof_pulse, resp_valid, irq, er;
  logic osc_autotune_on, osc_trim_up, osc_trim_down, supply_regulator_select;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] tok_ep, xfer_ep, resp_code, e;
  logic [7:0] v;
  logic [7:0] ix[7] = '{IDX_MISC, IDX_EP1, IDX_EP2, IDX_EP3, IDX_EP4, IDX_IRQ_STATUS,
    IDX_IRQ_MASK};
  int gp[3] = '{150, 200, 250};
  int failures = 0;
  int compares = 0;
  int up_n = 0;
  int dn_n = 0;
  int md, st_m;
  int ep_m[4];
  logic [1:0] exp_q[$];
  uecs_top #(.SOF_CYCLES(SOFC), .MODE_TABLE(256'h1806_2401_0000)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_dplus(usb_dplus), .sof_pulse(sof_pulse), .tok_valid(tok_valid),
    .tok_ep(tok_ep), .tok_is_in(tok_is_in), .resp_valid(resp_valid), .resp_code(resp_code),
    .xfer_done(xfer_done), .xfer_ep(xfer_ep), .xfer_acked(xfer_acked),
    .xfer_naked(xfer_naked), .osc_autotune_on(osc_autotune_on), .osc_trim_up(osc_trim_up),
    .osc_trim_down(osc_trim_down), .supply_regulator_select(supply_regulator_select),
    .irq(irq));
  uecs_host_model i_host (.pclk(pclk), .usb_dplus(usb_dplus), .sof_pulse(sof_pulse));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    if (osc_trim_up === 1'b1) up_n++;
    if (osc_trim_down === 1'b1) dn_n++;
  end
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, {24'h0, d}, 4'hf);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {2'h0, idx, 2'h0}, 32'h0, 4'hf);
    chk(nm, rd, exp);
  endtask
  task automatic tok(input logic [1:0] ep, input logic in, input logic [1:0] exp);
    @(posedge pclk);
    {tok_valid, tok_ep, tok_is_in} <= {1'b1, ep, in};
    @(posedge pclk);
    tok_valid <= 1'b0;
    @(negedge pclk);
    chk("resp_valid", resp_valid, 32'h1);
    chk("resp_code", resp_code, exp);
  endtask
  task automatic xfer(input logic [1:0] ep, input logic a, input logic nk);
    @(posedge pclk);
    {xfer_done, xfer_ep, xfer_acked, xfer_naked} <= {1'b1, ep, a, nk};
    @(posedge pclk);
    xfer_done <= 1'b0;
  endtask
  function automatic logic [1:0] resp_m(input int m, input logic in, input logic st);
    if (st && (m == 1) == in) return RESP_STALL;
    if (m == 1) return in ? RESP_ACK : RESP_NONE;
    return in ? RESP_NAK : RESP_ACK;
  endfunction
  initial begin
    {psel, penable, pwrite, tok_valid, tok_is_in, xfer_done, xfer_acked, xfer_naked} = '0;
    {paddr, pwdata, pstrb, tok_ep, xfer_ep} = '0;
    presetn = 1'b0;
    void'($urandom(36));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdc("reset", ix[i], 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_MISC, {5'h0, 1'b1, i[1:0]});
      rdc("misc", IDX_MISC, 32'(i));
      chk("autotune", osc_autotune_on, 32'(i[1]));
      chk("regsel", supply_regulator_select, 32'(i[0]));
    end
    // Autotune left on from here until the trim_off check
    i_host.burst(4);
    repeat (4) @(posedge pclk);
    rdc("traffic", IDX_MISC, 32'h7);
    wr(IDX_MISC, 8'h07);
    rdc("keep", IDX_MISC, 32'h7);
    wr(IDX_MISC, 8'h03);
    rdc("clear", IDX_MISC, 32'h3);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom) & 8'hbf;
      ep_m[k] = v & 8'haf;
      wr(8'(IDX_EP1 + k), v);
      rdc("ep", 8'(IDX_EP1 + k), ep_m[k]);
    end
    for (int k = 0; k < 8; k++) begin
      e = 2'($urandom);
      md = k[1] ? 2 : 1;
      wr(8'(IDX_EP1 + e), {k[2], 3'h0, 4'(md)});
      exp_q.push_back(resp_m(md, k[0], k[2]));
      tok(e, k[0], exp_q.pop_front());
    end
    e = 2'($urandom);
    wr(IDX_IRQ_MASK, 8'h0f);
    wr(8'(IDX_EP1 + e), 8'h21);
    xfer(e, 1'b1, 1'b0);
    rdc("acked", 8'(IDX_EP1 + e), 32'h32);
    chk("irq", irq, 32'h1);
    st_m = 1 << e;
    xfer(e, 1'b0, 1'b1);
    st_m |= 16 << e;
    rdc("status", IDX_IRQ_STATUS, st_m);
    wr(8'(IDX_EP1 + e), 8'h12);
    rdc("wrclr", 8'(IDX_EP1 + e), 32'h2);
    wr(IDX_IRQ_STATUS, 8'hff);
    xfer(e, 1'b0, 1'b1);
    rdc("nonak", IDX_IRQ_STATUS, 32'h0);
    chk("irq", irq, 32'h0);
    wr(IDX_IRQ_MASK, 8'hf0);
    xfer(e, 1'b1, 1'b0);
    rdc("mode", 8'(IDX_EP1 + e), 32'h11);
    chk("irqmask", irq, 32'h0);
    apb(1'b0, 12'h305, 32'h0, 4'hf);
    chk("misalign", er, 32'h1);
    apb(1'b0, 12'h140, 32'h0, 4'hf);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, {2'h0, IDX_MISC, 2'h0}, 32'h0, 4'h0);
    rdc("nostrb", IDX_MISC, 32'h3);
    i_host.frame(10);
    for (int i = 0; i < 3; i++) begin
      {up_n, dn_n} = '0;
      i_host.frame(gp[i]);
      repeat (3) @(posedge pclk);
      chk("trim_up", up_n, 32'(gp[i] < SOFC - TRIM_TOL_CYCLES));
      chk("trim_dn", dn_n, 32'(gp[i] > SOFC + TRIM_TOL_CYCLES));
    end
    wr(IDX_MISC, 8'h01);
    {up_n, dn_n} = '0;
    i_host.frame(10);
    i_host.frame(150);
    repeat (3) @(posedge pclk);
    chk("trim_off", up_n + dn_n, 32'h0);
    final_report();
  end
endmodule // tb_top
